//--- dv/pfshm_core_asserts.sv
`timescale 1ns/1ps
module pfshm_core_asserts (
	input wire clk_sys,
	input wire sys_rst,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire line_start,
	input wire pix_valid,
	input wire pix_out_valid,
	input wire [11:0] pix_color
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	pix_follow_a: assert property (
		pix_valid && !line_start |=> pix_out_valid) else $error("no pixel");
	pix_quiet_a: assert property (
		!pix_valid || line_start |=> !pix_out_valid) else $error("extra pixel");
	color_hold_a: assert property (
		!pix_out_valid |-> $stable(pix_color)) else $error("colour moved");
	bvalid_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
	bvalid_clear_a: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b stuck");
	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("r dropped");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no r");
	unmapped_zero_a: assert property (
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("bad data");
	cover property (line_start ##3 pix_out_valid);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind pfshm_core pfshm_core_asserts CHK (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.line_start(line_start), .pix_valid(pix_valid),
	.pix_out_valid(pix_out_valid), .pix_color(pix_color));

//--- dv/pfshm_core_bench.sv
`timescale 1ns/1ps
`include "pfshm_consts.vh"
module pfshm_core_bench;
	logic clk_sys, sys_rst, awv, wv, bry, arv, rry, ls, pv, hm;
	logic [7:0] awa, ara, dly;
	logic [31:0] wd, d;
	logic [1:0] r;
	logic [5:0] pb;
	logic [11:0] held, ex;
	logic [11:0] pal [32];
	logic [5:0] hist [32];
	logic [15:0] lf, ctl;
	logic [23:0] md [10] = '{24'h500000, 24'h580000, 24'h6c0000, 24'he80000,
		24'h480000, 24'h780000, 24'h680000, 24'h600073, 24'h6000f0, 24'he0005a};
	wire awr, wr, bv, arr, rv, pov;
	wire [1:0] rr, br;
	wire [31:0] rd;
	wire [11:0] pc, sc;
	wire [8:0] fs;
	wire [7:0] fw;
	wire [15:0] cnt;
	int failures, n_compared, i, n, m, npx;
	pfshm_core DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .line_start(ls), .pix_valid(pv),
		.plane_bits(pb), .pix_out_valid(pov), .pix_color(pc),
		.fetch_start(fs), .fetch_words(fw));
	pfshm_video_sink SINK (.clk_sys(clk_sys), .pix_out_valid(pov),
		.pix_color(pc), .shown_q(sc), .count_q(cnt));
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic hang(input logic dn);
		if (!dn) begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic dn;
		dn = 0;
		@(posedge clk_sys);
		awa <= a;
		wd <= v;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		for (int k = 0; k < 40 && !dn; k++) begin
			@(posedge clk_sys);
			if (awr) awv <= 0;
			if (wr) wv <= 0;
			dn = bv;
		end
		bry <= 0;
		hang(dn);
		#1;
		chk(br, 2'h0);
	endtask
	task automatic axr(input logic [7:0] a);
		logic dn;
		dn = 0;
		@(posedge clk_sys);
		ara <= a;
		arv <= 1;
		rry <= 1;
		for (int k = 0; k < 40 && !dn; k++) begin
			@(posedge clk_sys);
			if (arr) arv <= 0;
			dn = rv;
			d = rd;
			r = rr;
		end
		rry <= 0;
		hang(dn);
	endtask
	task automatic px(input logic [5:0] v);
		logic [5:0] b;
		for (int j = 31; j > 0; j--) hist[j] = hist[j-1];
		hist[0] = v;
		m = ctl[15] ? 2 : 1;
		b = hist[m * dly[3:0]] & 6'h15 | hist[m * dly[7:4]] & 6'h2a;
		b = b & ~(6'h3f << (ctl[14:12] == 3'h7 ? 3'h6 : ctl[14:12]));
		hm = ctl[11] && !ctl[10] && !ctl[15];
		hm = hm && (ctl[14:12] == 3'h5 || ctl[14:12] == 3'h6);
		if (!hm) ex = pal[b[4:0]];
		else if (b[5:4] == 2'h0) ex = pal[b[3:0]];
		else if (b[5:4] == 2'h1) ex = {held[11:4], b[3:0]};
		else if (b[5:4] == 2'h2) ex = {b[3:0], held[7:0]};
		else ex = {held[11:8], b[3:0], held[3:0]};
		held = ex;
		npx++;
		@(posedge clk_sys);
		pv <= 1;
		pb <= v;
		@(posedge clk_sys);
		pv <= 0;
		#1;
		chk(pc, ex);
		chk(pov, 1);
	endtask
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		{awv, wv, bry, arv, rry, ls, pv} = 7'h00;
		{awa, ara, wd, pb} = 54'h0;
		sys_rst = 1;
		lf = 16'h8543;
		failures = 0;
		n_compared = 0;
		npx = 0;
		for (i = 0; i < 32; i++) hist[i] = 6'h00;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 0;
		axr(`PFSHM_ADDR_PLANE_CTRL);
		chk(d, 0);
		axr(8'h40);
		chk(r, 2);
		axw(`PFSHM_ADDR_FETCH, 32'h8005_0038);
		chk(fs, 9'h038 - `PFSHM_EXTRA_FETCH_PIX);
		chk(fw, 8'h06);
		axw(`PFSHM_ADDR_FETCH, 32'h0005_0038);
		chk(fs, 9'h038);
		chk(fw, 8'h05);
		axw(`PFSHM_ADDR_SCROLL, 32'h0000_01a7);
		axr(`PFSHM_ADDR_SCROLL);
		chk(d, 32'h0000_00a7);
		for (i = 0; i < 32; i++) begin
			lf = nx(lf);
			pal[i] = lf[11:0];
			axw(`PFSHM_ADDR_PALETTE + 8'(4 * i), {16'h0, lf});
		end
		axr(8'h84);
		chk(d, 0);
		chk(r, 2'h0);
		for (i = 0; i < 10; i++) begin
			ctl = md[i][23:8];
			dly = md[i][7:0];
			axw(`PFSHM_ADDR_SCROLL, {24'h0, dly});
			axw(`PFSHM_ADDR_PLANE_CTRL, {16'h0, ctl});
			lstart_line();
			px(6'h1f);
			px(6'h3f);
			for (n = 0; n < 40; n++) begin
				lf = nx(lf);
				px(lf[5:0]);
			end
			axr(`PFSHM_ADDR_STATUS);
			chk(d, {19'h0, hm, held});
		end
		chk(cnt, npx);
		chk(sc, held);
		print_verdict();
	end
	task automatic lstart_line();
		@(posedge clk_sys);
		ls <= 1;
		@(posedge clk_sys);
		ls <= 0;
		held = pal[0];
	endtask
endmodule

//--- dv/pfshm_video_sink.sv
`timescale 1ns/1ps
module pfshm_video_sink (
	input wire clk_sys,
	input wire pix_out_valid,
	input wire [11:0] pix_color,
	output logic [11:0] shown_q,
	output logic [15:0] count_q
);
	// Output stage latches each colour it is handed
	initial count_q = 16'h0000;
	always @(posedge clk_sys) begin
		if (pix_out_valid) begin
			shown_q <= pix_color;
			count_q <= count_q + 16'h0001;
		end
	end
endmodule

//--- hw/pfshm_consts.vh
`ifndef PFSHM_CONSTS_VH
`define PFSHM_CONSTS_VH
// Register byte addresses
`define PFSHM_ADDR_PLANE_CTRL 8'h00
`define PFSHM_ADDR_SCROLL 8'h04
`define PFSHM_ADDR_FETCH 8'h08
`define PFSHM_ADDR_STATUS 8'h0c
`define PFSHM_ADDR_PALETTE 8'h80
// Plane control word fields
`define PFSHM_HIGH_RESOLUTION_ENABLE_BIT 15
`define PFSHM_CNT_HI 14
`define PFSHM_CNT_LO 12
`define PFSHM_HOLD_BIT 11
`define PFSHM_DUAL_BIT 10
`define PFSHM_CNT_FIVE 3'h5
`define PFSHM_CNT_SIX 3'h6
// Fetch register fields
`define PFSHM_SCROLL_EN_BIT 31
`define PFSHM_WORDS_HI 23
`define PFSHM_WORDS_LO 16
`define PFSHM_START_HI 8
`define PFSHM_START_LO 0
// Colour fields
`define PFSHM_RED_HI 11
`define PFSHM_RED_LO 8
`define PFSHM_GRN_HI 7
`define PFSHM_GRN_LO 4
`define PFSHM_BLU_HI 3
`define PFSHM_BLU_LO 0
// Scroll and timing figures
`define PFSHM_EXTRA_FETCH_PIX 9'h010
`define PFSHM_MAX_TAP 31
// Reset values
`define PFSHM_RST_PLANE_CTRL 16'h0000
`define PFSHM_RST_SCROLL 8'h00
`define PFSHM_RST_FETCH 32'h0000_0000
`define PFSHM_RST_COLOR 12'h000
`endif

//--- hw/pfshm_core.v
`timescale 1ns/1ps
`include "pfshm_consts.vh"
module pfshm_core (
	input wire clk_sys,
	input wire sys_rst,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire line_start,
	input wire pix_valid,
	input wire [5:0] plane_bits,
	output reg pix_out_valid,
	output reg [11:0] pix_color,
	output reg [8:0] fetch_start,
	output reg [7:0] fetch_words
);
	reg [15:0] plane_control_word_q;
	reg [7:0] scroll_delay_control_q;
	reg [31:0] fetch_ctrl_q;
	reg [11:0] palette_q [0:31];
	reg [11:0] hold_q;
	reg aw_full_q;
	reg w_full_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [89:0] odd_sr_q;
	reg [89:0] even_sr_q;
	reg [11:0] color_d;
	integer i;

	// Register kinds decoded from a byte address
	localparam KIND_NONE = 3'h0;
	localparam KIND_CTRL = 3'h1;
	localparam KIND_SCROLL = 3'h2;
	localparam KIND_FETCH = 3'h3;
	localparam KIND_STATUS = 3'h4;
	localparam KIND_PAL = 3'h5;

	function [2:0] reg_kind;
		input [7:0] addr;
		begin
			if (addr[1:0] != 2'h0)
				reg_kind = KIND_NONE;
			else if (addr[7] == 1'b1)
				reg_kind = KIND_PAL;
			else if (addr == `PFSHM_ADDR_PLANE_CTRL)
				reg_kind = KIND_CTRL;
			else if (addr == `PFSHM_ADDR_SCROLL)
				reg_kind = KIND_SCROLL;
			else if (addr == `PFSHM_ADDR_FETCH)
				reg_kind = KIND_FETCH;
			else if (addr == `PFSHM_ADDR_STATUS)
				reg_kind = KIND_STATUS;
			else
				reg_kind = KIND_NONE;
		end
	endfunction

	// Write channel: address and data taken in either order
	wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
	wire [2:0] wr_kind = reg_kind(aw_addr_q);
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign s_axi_bresp = 2'h0;
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register writes, honouring byte strobes
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			plane_control_word_q <= `PFSHM_RST_PLANE_CTRL;
			scroll_delay_control_q <= `PFSHM_RST_SCROLL;
			fetch_ctrl_q <= `PFSHM_RST_FETCH;
			for (i = 0; i < 32; i = i + 1) begin
				palette_q[i] <= `PFSHM_RST_COLOR;
			end
		end else if (do_write) begin
			case (wr_kind)
			KIND_CTRL: begin
				if (w_strb_q[0])
					plane_control_word_q[7:0] <= w_data_q[7:0];
				if (w_strb_q[1])
					plane_control_word_q[15:8] <= w_data_q[15:8];
			end
			KIND_SCROLL: begin
				if (w_strb_q[0])
					scroll_delay_control_q <= w_data_q[7:0];
			end
			KIND_FETCH: begin
				for (i = 0; i < 4; i = i + 1) begin
					if (w_strb_q[i])
						fetch_ctrl_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
				end
			end
			KIND_PAL: begin
				// Only 12 colour bits are kept
				if (w_strb_q[0])
					palette_q[aw_addr_q[6:2]][7:0] <= w_data_q[7:0];
				if (w_strb_q[1])
					palette_q[aw_addr_q[6:2]][11:8] <= w_data_q[11:8];
			end
			default: begin
			end
			endcase
		end
	end

	// Plane control decode
	wire high_resolution_enable = plane_control_word_q[`PFSHM_HIGH_RESOLUTION_ENABLE_BIT];
	wire [2:0] plane_cnt =
		plane_control_word_q[`PFSHM_CNT_HI:`PFSHM_CNT_LO];
	wire hold_active = plane_control_word_q[`PFSHM_HOLD_BIT] &&
		!plane_control_word_q[`PFSHM_DUAL_BIT] && !high_resolution_enable &&
		(plane_cnt == `PFSHM_CNT_FIVE ||
		plane_cnt == `PFSHM_CNT_SIX);

	// Read channel: answer one cycle after the address is taken
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (reg_kind(s_axi_araddr))
			KIND_CTRL:
				s_axi_rdata <= {16'h0000, plane_control_word_q};
			KIND_SCROLL:
				s_axi_rdata <= {24'h000000, scroll_delay_control_q};
			KIND_FETCH:
				s_axi_rdata <= fetch_ctrl_q;
			KIND_STATUS:
				s_axi_rdata <= {19'h00000, hold_active, hold_q};
			KIND_PAL:
				s_axi_rdata <= 32'h0000_0000;
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Fetch window: extra word and earlier start when scrolling
	wire scroll_en = fetch_ctrl_q[`PFSHM_SCROLL_EN_BIT];
	wire [8:0] start_norm =
		fetch_ctrl_q[`PFSHM_START_HI:`PFSHM_START_LO];
	wire [7:0] words_norm =
		fetch_ctrl_q[`PFSHM_WORDS_HI:`PFSHM_WORDS_LO];

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			fetch_start <= 9'h000;
			fetch_words <= 8'h00;
		end else if (scroll_en) begin
			fetch_start <= start_norm - `PFSHM_EXTRA_FETCH_PIX;
			fetch_words <= words_norm + 8'h01;
		end else begin
			fetch_start <= start_norm;
			fetch_words <= words_norm;
		end
	end

	// Planes beyond the enabled count read as zero
	wire [5:0] plane_mask = (plane_cnt >= 3'h6) ? 6'h3f :
		(6'h3f >> (3'h6 - plane_cnt));
	wire [5:0] planes_in = plane_bits & plane_mask;
	wire [2:0] odd_in = {planes_in[4], planes_in[2], planes_in[0]};
	wire [2:0] even_in = {planes_in[5], planes_in[3], planes_in[1]};

	// Per playfield delay lines, one tap per pixel of delay
	wire [2:0] odd_out;
	wire [2:0] even_out;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_field
			wire [3:0] dly = scroll_delay_control_q[g*4 +: 4];
			wire [4:0] tap = high_resolution_enable ? {dly, 1'b0} : {1'b0, dly};
			wire [92:0] line = (g == 0) ? {odd_sr_q, odd_in} :
				{even_sr_q, even_in};
			wire [2:0] sel = line[tap*3 +: 3];
			if (g == 0) begin : g_odd
				assign odd_out = sel;
			end else begin : g_even
				assign even_out = sel;
			end
		end
	endgenerate

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			odd_sr_q <= 90'h0;
			even_sr_q <= 90'h0;
		end else if (pix_valid) begin
			odd_sr_q <= {odd_sr_q[86:0], odd_in};
			even_sr_q <= {even_sr_q[86:0], even_in};
		end
	end

	// Delayed pixel as plane 6..1
	wire [5:0] pix = {even_out[2], odd_out[2], even_out[1], odd_out[1],
		even_out[0], odd_out[0]};
	wire [3:0] mod_val = pix[3:0];

	always @* begin
		color_d = palette_q[pix[4:0]];
		if (hold_active) begin
			case (pix[5:4])
			2'h0:
				color_d = palette_q[{1'b0, mod_val}];
			2'h1:
				color_d = {hold_q[`PFSHM_RED_HI:`PFSHM_GRN_LO],
					mod_val};
			2'h2:
				color_d = {mod_val,
					hold_q[`PFSHM_GRN_HI:`PFSHM_BLU_LO]};
			2'h3:
				color_d = {hold_q[`PFSHM_RED_HI:`PFSHM_RED_LO], mod_val,
					hold_q[`PFSHM_BLU_HI:`PFSHM_BLU_LO]};
			default:
				color_d = palette_q[0];
			endcase
		end
	end

	// Output colour and held colour
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hold_q <= `PFSHM_RST_COLOR;
			pix_color <= `PFSHM_RST_COLOR;
			pix_out_valid <= 1'b0;
		end else begin
			// A pixel that meets line_start is not shown
			pix_out_valid <= pix_valid && !line_start;
			if (line_start) begin
				hold_q <= palette_q[0];
			end else if (pix_valid) begin
				hold_q <= color_d;
				pix_color <= color_d;
			end
		end
	end
endmodule
